// *** src/trdc_top.sv ***
// Readout side of the trigger serialiser: demux, capture memory, FIFO,
// shift register, playback and calibration pattern.
// Assumes all inputs synchronous to clk_sys; crossings come from a divider.
//
// Overview of operation
// - Four identical demux units cover the 40-bit parallel input word.
// - Each unit sees eight data bits, one flag bit and one parity bit.
// - Non-zero data starts a two-crossing pair; flag picks the tower.
// - Towers without data in a crossing read zero except the parity error bit.
// - Each 10-bit word becomes 18 bits: two towers of data and parity.
// - Bypass skips demux; slices stay 80 bits, unused fields zero.
// - Parity checked alongside demux; error marks all affected towers.
// - Parity errors counted; summary pin high while any count nonzero.
// - Readout, load and resync inputs sampled on the crossing enable edge.
// - Each crossing with readout request copies one slice to FIFO unless it is full.
// - Empty flag low while the FIFO holds data.
// - Load request moves one slice to the shifter, shifted per crossing.
// - Resync clears write pointer and loads read pointer with offset.
// - Playback feeds capture memory to the output path instead.
// - Calibration outputs a repeating A5 byte pattern.
// - Seven-bit pointers advance every crossing and wrap.
// - Read pointer leads write pointer by the offset setting.
// - Shifter runs always; zeros follow the 80 valid bits.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module trdc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [trdc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [trdc_pkg::BUS_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [trdc_pkg::BUS_W-1:0] reg_rdata,
  // Channel input
  input wire logic [trdc_pkg::RAW_W-1:0] ch_data,
  // Readout controller
  input wire logic readout_request,
  input wire logic shift_load_request,
  input wire logic pointer_resync,
  output logic buffer_empty_flag,
  output logic fifo_full_flag,
  output logic readout_serial,
  // Timing command link
  input wire logic tcl_playback_start,
  input wire logic tcl_playback_stop,
  input wire logic tcl_calib_start,
  input wire logic tcl_calib_stop,
  // Real-time output and status
  output logic [trdc_pkg::RAW_W-1:0] rt_data,
  output logic parity_error
);
  typedef struct packed {
    logic [trdc_pkg::DIV_W-1:0] div;
    logic bx;
    logic [trdc_pkg::PTR_W-1:0] wptr;
    logic [trdc_pkg::PTR_W-1:0] rptr;
    logic [trdc_pkg::PTR_W-1:0] offset;
    logic bypass;
    logic playback;
    logic calib;
    logic [trdc_pkg::PTR_W-1:0] fwp;
    logic [trdc_pkg::PTR_W-1:0] frp;
    logic [trdc_pkg::CNT_W-1:0] fcnt;
    logic empty;
    logic full;
    logic [trdc_pkg::SLICE_W-1:0] sr;
    logic [trdc_pkg::BITCNT_W-1:0] bits;
    logic sout;
    logic [trdc_pkg::NUM_CH-1:0][trdc_pkg::ERR_W-1:0] err;
    logic perr;
    logic [trdc_pkg::RAW_W-1:0] rt;
    logic [trdc_pkg::BUS_W-1:0] rdata;
  } trdc_state_type;

  trdc_state_type s_q, s_d;
  logic [trdc_pkg::MEM_W-1:0] cap_mem [0:trdc_pkg::DEPTH-1];
  logic [trdc_pkg::SLICE_W-1:0] fifo_mem [0:trdc_pkg::DEPTH-1];
  logic [trdc_pkg::NUM_CH*trdc_pkg::RES_W-1:0] dmx_res;
  logic [trdc_pkg::NUM_CH-1:0] dmx_err;
  logic [trdc_pkg::SLICE_W-1:0] live_slice;
  logic [trdc_pkg::MEM_W-1:0] cap_rd;
  logic push;
  logic pop;

  genvar gi;
  generate
    for (gi = 0; gi < trdc_pkg::NUM_CH; gi++) begin : g_ch
      trdc_demux u_dmx (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .bx_en(s_q.bx),
        .bypass(s_q.bypass),
        .ch_word(ch_data[gi*trdc_pkg::CH_W +: trdc_pkg::CH_W]),
        .result(dmx_res[gi*trdc_pkg::RES_W +: trdc_pkg::RES_W]),
        .parity_err(dmx_err[gi])
      );
    end
  endgenerate

  // Slice padded to 80 bits in either mode
  assign live_slice = {{trdc_pkg::PAD_W{1'b0}}, dmx_res};
  assign cap_rd = cap_mem[s_q.rptr];
  // Controller strobes taken on the crossing enable edge
  assign push = s_q.bx && readout_request && !s_q.full;
  assign pop = s_q.bx && shift_load_request && !s_q.empty;

  always_ff @(posedge clk_sys) begin
    if (s_q.bx) begin
      cap_mem[s_q.wptr] <= {ch_data, live_slice};
    end
    if (push) begin
      fifo_mem[s_q.fwp] <= cap_rd[trdc_pkg::SLICE_W-1:0];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    // Crossing enable divider
    s_d.bx = (s_q.div == trdc_pkg::DIV_LAST);
    s_d.div = s_d.bx ? '0 : s_q.div + 1'b1;
    // Register writes
    if (reg_wr && reg_addr == trdc_pkg::ADDR_CTRL) begin
      s_d.bypass = reg_wdata[trdc_pkg::CTRL_BYPASS];
      s_d.playback = reg_wdata[trdc_pkg::CTRL_PLAYBACK];
      s_d.calib = reg_wdata[trdc_pkg::CTRL_CALIB];
    end
    if (reg_wr && reg_addr == trdc_pkg::ADDR_OFFSET) begin
      s_d.offset = reg_wdata[trdc_pkg::PTR_W-1:0];
    end
    // Broadcast commands override a same-cycle register write
    if (tcl_playback_start) begin
      s_d.playback = 1'b1;
    end else if (tcl_playback_stop) begin
      s_d.playback = 1'b0;
    end
    if (tcl_calib_start) begin
      s_d.calib = 1'b1;
    end else if (tcl_calib_stop) begin
      s_d.calib = 1'b0;
    end
    // Error counters: a write clears, a new error in that cycle still counts
    for (int i = 0; i < trdc_pkg::NUM_CH; i++) begin
      if (reg_wr && reg_addr == trdc_pkg::ADDR_ERR0 + trdc_pkg::ADDR_W'(i)) begin
        s_d.err[i] = '0;
      end
      if (s_q.bx && dmx_err[i] && s_d.err[i] != trdc_pkg::ERR_MAX) begin
        s_d.err[i] = s_d.err[i] + 1'b1;
      end
    end
    s_d.perr = (s_d.err != '0);
    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        trdc_pkg::ADDR_CTRL: begin
          s_d.rdata[trdc_pkg::CTRL_BYPASS] = s_q.bypass;
          s_d.rdata[trdc_pkg::CTRL_PLAYBACK] = s_q.playback;
          s_d.rdata[trdc_pkg::CTRL_CALIB] = s_q.calib;
        end
        trdc_pkg::ADDR_OFFSET: begin
          s_d.rdata[trdc_pkg::PTR_W-1:0] = s_q.offset;
        end
        trdc_pkg::ADDR_STATUS: begin
          s_d.rdata[trdc_pkg::PTR_W-1:0] = s_q.wptr;
          s_d.rdata[trdc_pkg::STAT_EMPTY] = s_q.empty;
          s_d.rdata[trdc_pkg::STAT_FULL] = s_q.full;
          s_d.rdata[trdc_pkg::STAT_PERR] = s_q.perr;
        end
        default: begin
          for (int i = 0; i < trdc_pkg::NUM_CH; i++) begin
            if (reg_addr == trdc_pkg::ADDR_ERR0 + trdc_pkg::ADDR_W'(i)) begin
              s_d.rdata = s_q.err[i];
            end
          end
        end
      endcase
    end
    if (s_q.bx) begin
      // Pointers
      if (pointer_resync) begin
        s_d.wptr = '0;
        s_d.rptr = s_q.offset;
      end else begin
        s_d.wptr = s_q.wptr + 1'b1;
        s_d.rptr = s_q.rptr + 1'b1;
      end
      // Real-time output path
      if (s_q.calib) begin
        s_d.rt = {trdc_pkg::RAW_W/trdc_pkg::DATA_W{trdc_pkg::CAL_BYTE}};
      end else if (s_q.playback) begin
        s_d.rt = cap_rd[trdc_pkg::MEM_W-1 -: trdc_pkg::RAW_W];
      end else begin
        s_d.rt = ch_data;
      end
      // Shifter runs every crossing, zeros fill behind
      s_d.sout = s_q.sr[trdc_pkg::SLICE_W-1];
      s_d.sr = {s_q.sr[trdc_pkg::SLICE_W-2:0], 1'b0};
      if (s_q.bits != '0) begin
        s_d.bits = s_q.bits - 1'b1;
      end
    end
    // FIFO
    if (push) begin
      s_d.fwp = s_q.fwp + 1'b1;
    end
    if (pop) begin
      s_d.frp = s_q.frp + 1'b1;
      s_d.sr = fifo_mem[s_q.frp];
      s_d.bits = trdc_pkg::SLICE_BITS;
    end
    s_d.fcnt = s_q.fcnt + trdc_pkg::CNT_W'(push) - trdc_pkg::CNT_W'(pop);
    s_d.empty = (s_d.fcnt == '0);
    s_d.full = (s_d.fcnt == trdc_pkg::FIFO_FULL_CNT);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.offset <= trdc_pkg::OFFSET_RST;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign buffer_empty_flag = s_q.empty;
  assign fifo_full_flag = s_q.full;
  assign readout_serial = s_q.sout;
  assign rt_data = s_q.rt;
  assign parity_error = s_q.perr;

  a_fifo_push:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    push && !pop |=> s_q.fcnt == $past(s_q.fcnt) + 1'b1)
  else $error("Readout request did not add one slice");

  a_empty_clears:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    push && s_q.empty |=> !buffer_empty_flag)
  else $error("Empty flag stayed high after a push");

  a_full_ignore:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_q.full && readout_request && !pop |=> s_q.fcnt == $past(s_q.fcnt))
  else $error("Full FIFO accepted a slice");

  a_resync_ptrs:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_q.bx && pointer_resync
    |=> s_q.wptr == '0 && s_q.rptr == $past(s_q.offset))
  else $error("Resync did not reload pointers");

  a_ptr_advance:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_q.bx && !pointer_resync
    |=> s_q.wptr == $past(s_q.wptr) + 1'b1
        && s_q.rptr - s_q.wptr == $past(s_q.rptr - s_q.wptr))
  else $error("Pointers did not advance together");

  a_err_pin:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    parity_error == (s_q.err != '0))
  else $error("Parity error pin disagrees with counters");

  a_err_saturate:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_q.err[0] == trdc_pkg::ERR_MAX && !reg_wr
    |=> s_q.err[0] == trdc_pkg::ERR_MAX)
  else $error("Error counter wrapped");

  a_calib_pattern:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_q.bx && s_q.calib |=> rt_data[7:0] == trdc_pkg::CAL_BYTE
        && rt_data[39:32] == trdc_pkg::CAL_BYTE)
  else $error("Calibration pattern missing");

  a_shift_zeros:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_q.bx && s_q.bits == '0 && !pop ##1 s_q.bits == '0 |=> !readout_serial)
  else $error("Shifter output not zero after slice");
endmodule // trdc_top
`default_nettype wire

// *** src/trdc_pkg.sv ***
// Constants shared by the trigger readout demux/control block.
// Assumes a 125 MHz system clock; bunch crossings are derived by division.
package trdc_pkg;
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BX_PERIOD_PS = 25000;
  // Longest spacing rounds down, never below one cycle
  localparam int BX_CYCLES_RAW = BX_PERIOD_PS / CLK_PERIOD_PS;
  localparam int BX_CYCLES = (BX_CYCLES_RAW < 1) ? 1 : BX_CYCLES_RAW;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BX_CYCLES - 1);
  // Widths and depths
  localparam int NUM_CH = 4;
  localparam int CH_W = 10;
  localparam int DATA_W = 8;
  localparam int TOWER_W = 9;
  localparam int RES_W = 18;
  localparam int RAW_W = 40;
  localparam int SLICE_W = 80;
  localparam int PAD_W = SLICE_W - NUM_CH * RES_W;
  localparam int MEM_W = RAW_W + SLICE_W;
  localparam int PTR_W = 7;
  localparam int DEPTH = 128;
  localparam int CNT_W = 8;
  localparam int ERR_W = 16;
  localparam int BITCNT_W = 7;
  localparam int ADDR_W = 4;
  localparam int BUS_W = 16;
  // Channel word fields
  localparam int PAR_BIT = 0;
  localparam int FLAG_BIT = 1;
  localparam int DATA_LSB = 2;
  // Register offsets (word index)
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_ERR0 = 4'h4;
  // Control register bits
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_PLAYBACK = 1;
  localparam int CTRL_CALIB = 2;
  // Status register bits
  localparam int STAT_EMPTY = 8;
  localparam int STAT_FULL = 9;
  localparam int STAT_PERR = 10;
  // Values
  localparam logic [DATA_W-1:0] CAL_BYTE = 8'hA5;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 8'h80;
  localparam logic [ERR_W-1:0] ERR_MAX = 16'hFFFF;
  localparam logic [BITCNT_W-1:0] SLICE_BITS = 7'h50;
  localparam logic [PTR_W-1:0] OFFSET_RST = 7'h00;
endpackage

// *** src/trdc_demux.sv ***
// One bunch-crossing de-multiplexer with parity check for a 10-bit channel.
// Assumes bx_en is a one-cycle pulse once per bunch crossing.
`timescale 1ns/100ps
`default_nettype none
module trdc_demux (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic bx_en,
  input wire logic bypass,
  // Channel word and result
  input wire logic [trdc_pkg::CH_W-1:0] ch_word,
  output logic [trdc_pkg::RES_W-1:0] result,
  output logic parity_err
);
  typedef struct packed {
    logic phase;
    logic [trdc_pkg::CH_W-1:0] first;
    logic first_err;
    logic [trdc_pkg::RES_W-1:0] res;
    logic perr;
  } trdc_dmx_state_type;

  trdc_dmx_state_type s_q, s_d;
  logic [trdc_pkg::DATA_W-1:0] data;
  logic [trdc_pkg::DATA_W-1:0] fdata;
  logic err;
  logic either;

  assign data = ch_word[trdc_pkg::DATA_LSB +: trdc_pkg::DATA_W];
  assign fdata = s_q.first[trdc_pkg::DATA_LSB +: trdc_pkg::DATA_W];
  // Even parity over data, flag and parity bit
  assign err = ^ch_word;
  assign either = err | s_q.first_err;

  always_comb begin
    s_d = s_q;
    if (bx_en) begin
      s_d.perr = err;
      s_d.res = '0;
      if (bypass) begin
        s_d.phase = 1'b0;
        s_d.res[0 +: trdc_pkg::TOWER_W] = {data, err};
      end else if (s_q.phase) begin
        s_d.phase = 1'b0;
        s_d.perr = either;
        if (s_q.first[trdc_pkg::FLAG_BIT]) begin
          s_d.res = {fdata, either, data, either};
        end else begin
          s_d.res = {data, either, fdata, either};
        end
      end else if (data != '0) begin
        s_d.phase = 1'b1;
        s_d.first = ch_word;
        s_d.first_err = err;
        s_d.res[0] = err;
        s_d.res[trdc_pkg::TOWER_W] = err;
      end else begin
        s_d.res[0] = err;
        s_d.res[trdc_pkg::TOWER_W] = err;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.res;
  assign parity_err = s_q.perr;

  a_zero_tower:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    bx_en && !bypass && !s_q.phase && data == '0 && !err
    |=> result == '0)
  else $error("Unassigned towers not zero");

  a_pair_close:
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    bx_en && !bypass && !s_q.phase && data != '0
    |=> s_q.phase ##3 !s_q.phase)
  else $error("Pair not closed on second crossing");
endmodule // trdc_demux
`default_nettype wire

// *** tb/trdc_roc.sv ***
// Readout controller model that requests slices and unloads them.
// Assumes a crossing every third clk_sys cycle; levels span whole crossings.
`timescale 1ns/100ps
`default_nettype none
module trdc_roc (
  // Clock
  input wire logic clk_sys,
  // Controller lines
  output logic readout_request,
  output logic shift_load_request,
  output logic pointer_resync,
  input wire logic buffer_empty_flag
);
  initial begin
    readout_request = 1'b0;
    shift_load_request = 1'b0;
    pointer_resync = 1'b0;
  end
  task automatic crossings(input int n);
    repeat (3 * n) @(posedge clk_sys);
  endtask
  task automatic resync();
    pointer_resync <= 1'b1;
    crossings(1);
    pointer_resync <= 1'b0;
  endtask
  task automatic request(input int n);
    readout_request <= 1'b1;
    crossings(n);
    readout_request <= 1'b0;
  endtask
  // One load per requested slice, each after the flag shows data
  task automatic event_read(input int slices);
    request(slices);
    for (int i = 0; i < slices; i++) begin
      for (int t = 0; t < 30 && buffer_empty_flag !== 1'b0; t++) begin
        @(posedge clk_sys);
      end
      shift_load_request <= 1'b1;
      crossings(1);
      shift_load_request <= 1'b0;
      crossings(80);
    end
  endtask
endmodule // trdc_roc
`default_nettype wire

// *** tb/trdc_top_tb_top.sv ***
// Self-checking bench for the trigger readout block.
// Assumes one 125 MHz clock and the controller model beside the design.
`timescale 1ns/100ps
`default_nettype none
module trdc_top_tb_top;
  logic clk_sys, reset_n, reg_wr, reg_rd, readout_serial, parity_error;
  logic readout_request, shift_load_request, pointer_resync;
  logic buffer_empty_flag, fifo_full_flag;
  logic tcl_playback_start, tcl_playback_stop, tcl_calib_start, tcl_calib_stop;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, w1, rnd;
  logic [39:0] ch_data, rt_data, word_a, word_b;
  logic [79:0] q_slices[$];
  int n_mismatch, comparisons, cycles;

  trdc_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch_data(ch_data),
    .readout_request(readout_request),
    .shift_load_request(shift_load_request),
    .pointer_resync(pointer_resync), .buffer_empty_flag(buffer_empty_flag),
    .fifo_full_flag(fifo_full_flag), .readout_serial(readout_serial),
    .tcl_playback_start(tcl_playback_start),
    .tcl_playback_stop(tcl_playback_stop),
    .tcl_calib_start(tcl_calib_start), .tcl_calib_stop(tcl_calib_stop),
    .rt_data(rt_data), .parity_error(parity_error));
  trdc_roc ROC (.clk_sys(clk_sys), .readout_request(readout_request),
    .shift_load_request(shift_load_request), .pointer_resync(pointer_resync),
    .buffer_empty_flag(buffer_empty_flag));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Even-parity channel words; channel 3 data always has its top bit set
  function automatic logic [39:0] rand_word();
    logic [39:0] w;
    logic [7:0] dd;
    for (int c = 0; c < 4; c++) begin
      rnd = lfsr(rnd);
      dd = rnd[7:0] | ((c == 3) ? 8'h80 : 8'h00);
      w[10*c +: 10] = {dd, 1'b0, ^dd};
    end
    return w;
  endfunction
  // Bypass slice: tower0 of each channel carries data and error, rest zero
  function automatic logic [79:0] slice_of(input logic [39:0] w);
    logic [79:0] s;
    s = '0;
    for (int c = 0; c < 4; c++) begin
      s[18*c +: 9] = {w[10*c+2 +: 8], ^w[10*c +: 10]};
    end
    return s;
  endfunction

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk_v(input logic [39:0] got, input logic [39:0] exp,
    input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge clk_sys);
  endtask
  // Finds the first data bit, then checks bits 62..0 mid-crossing
  task automatic check_serial(input logic [79:0] s, input bit last);
    int n;
    n = 0;
    if (!last) begin
      repeat (8) step();
      chk_b(buffer_empty_flag, 1'b0, "empty flag");
    end
    while (readout_serial !== 1'b1 && n < 120) begin
      step();
      n++;
    end
    chk_b(readout_serial, 1'b1, "serial start");
    step();
    for (int k = 62; k >= 0; k--) begin
      chk_b(readout_serial, s[k], "serial bit");
      repeat (3) step();
    end
    if (last) begin
      repeat (10) begin
        chk_b(readout_serial, 1'b0, "zero fill");
        repeat (3) step();
      end
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, tcl_playback_start, tcl_playback_stop} = 4'h0;
    {tcl_calib_start, tcl_calib_stop} = 2'h0;
    reg_addr = '0;
    reg_wdata = '0;
    ch_data = '0;
    rnd = 16'hB5D1;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 8; a++) begin
      reg_read(4'(a), d);
      if (a == 2) d = d & 16'hFF00;
      chk_v(40'(d), (a == 2) ? 40'h100 : 40'h0, "reset value");
    end
    reg_write(trdc_pkg::ADDR_OFFSET, 16'h0005);
    reg_read(trdc_pkg::ADDR_OFFSET, d);
    chk_v(40'(d[6:0]), 40'h5, "offset");
    word_a = rand_word();
    ch_data <= word_a;
    reg_write(trdc_pkg::ADDR_CTRL, 16'h0001);
    reg_read(trdc_pkg::ADDR_STATUS, w1);
    repeat (388) @(posedge clk_sys);
    reg_read(trdc_pkg::ADDR_STATUS, d);
    chk_v(40'(d[6:0]), 40'(7'(w1[6:0] + 7'h2)), "pointer wrap");
    ROC.resync();
    reg_read(trdc_pkg::ADDR_STATUS, d);
    chk_b(d[6:0] < 7'h2, 1'b1, "resync pointer");
    q_slices.push_back(slice_of(word_a));
    q_slices.push_back(slice_of(word_a));
    fork
      ROC.event_read(2);
      begin
        check_serial(q_slices.pop_front(), 1'b0);
        check_serial(q_slices.pop_front(), 1'b1);
      end
    join
    @(posedge clk_sys);
    chk_b(buffer_empty_flag, 1'b1, "empty after drain");
    ch_data <= word_a ^ 40'h1;
    repeat (12) @(posedge clk_sys);
    ch_data <= word_a;
    repeat (9) @(posedge clk_sys);
    reg_read(trdc_pkg::ADDR_ERR0, d);
    chk_v(40'(d), 40'h4, "error count");
    chk_b(parity_error, 1'b1, "error pin");
    reg_write(trdc_pkg::ADDR_ERR0, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk_b(parity_error, 1'b0, "error pin clear");
    reg_write(trdc_pkg::ADDR_CTRL, 16'h0005);
    repeat (6) @(posedge clk_sys);
    chk_v(rt_data, {5{8'hA5}}, "calib register");
    reg_write(trdc_pkg::ADDR_CTRL, 16'h0000);
    tcl_calib_start <= 1'b1;
    @(posedge clk_sys);
    tcl_calib_start <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk_v(rt_data, {5{8'hA5}}, "calib command");
    tcl_calib_stop <= 1'b1;
    @(posedge clk_sys);
    tcl_calib_stop <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk_v(rt_data, word_a, "live data");
    word_b = rand_word();
    ch_data <= word_b;
    tcl_playback_start <= 1'b1;
    @(posedge clk_sys);
    tcl_playback_start <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk_v(rt_data, word_a, "playback");
    tcl_playback_stop <= 1'b1;
    @(posedge clk_sys);
    tcl_playback_stop <= 1'b0;
    // Bursts of five slices per accept, one idle crossing between
    repeat (26) begin
      ROC.request(5);
      ROC.crossings(1);
    end
    repeat (2) @(posedge clk_sys);
    chk_b(fifo_full_flag, 1'b1, "full flag");
    reg_read(trdc_pkg::ADDR_STATUS, d);
    chk_v(40'(d[10:8]), 40'h2, "status full");
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_b(buffer_empty_flag & ~fifo_full_flag, 1'b1, "reset flags");
    reset_n <= 1'b1;
    report_and_stop();
  end
endmodule // trdc_top_tb_top
`default_nettype wire
